// ==== inc/asc_pkg.sv ====
// Shared constants and types of the converter scan and command control
package asc_pkg;

	// ------------------------------------------------------------
	// Command byte layouts
	// ------------------------------------------------------------
	typedef struct packed {
		logic       sel;
		logic [3:0] chan;
		logic [1:0] sweep;
		logic       temp;
	} asc_conv_cmd_t;

	typedef struct packed {
		logic [1:0] sel;
		logic [1:0] clk_mode;
		logic [1:0] ref_mode;
		logic [1:0] pol_sel;
	} asc_setup_cmd_t;

	// Request handed to the converter core with each start pulse
	typedef struct packed {
		logic [3:0] chan;
		logic       diff;
		logic       temp;
		logic       bias_low;
	} asc_adc_req_t;

	// ------------------------------------------------------------
	// Encodings and reset values
	// ------------------------------------------------------------
	localparam logic       CONV_SEL     = 1'h1;
	localparam logic [1:0] SETUP_SEL    = 2'h1;
	localparam logic [1:0] CLK_INT_PIN  = 2'h0;
	localparam logic [1:0] CLK_INT_ACQ  = 2'h1;
	localparam logic [1:0] CLK_INT_WR   = 2'h2;
	localparam logic [1:0] CLK_EXT      = 2'h3;
	localparam logic [1:0] REF_INT      = 2'h0;
	localparam logic [1:0] REF_EXT      = 2'h1;
	localparam logic [1:0] REF_ADC_INT  = 2'h2;
	localparam logic [1:0] REF_DIFF     = 2'h3;
	localparam logic [1:0] SW_UP_TO     = 2'h0;
	localparam logic [1:0] SW_FROM      = 2'h1;
	localparam logic [1:0] SW_REPEAT    = 2'h2;
	localparam logic [1:0] SW_ONCE      = 2'h3;
	localparam logic [1:0] CLK_MODE_RST = 2'h2;
	localparam logic [1:0] REF_MODE_RST = 2'h2;
	localparam logic [1:0] POL_SEL_RST  = 2'h0;

	// ------------------------------------------------------------
	// Channels, storage and timing
	// ------------------------------------------------------------
	localparam logic [3:0] TOP_CH       = 4'hb;
	localparam logic [3:0] START_PIN_CH = 4'hb;
	localparam logic [3:0] SEC_REF_CH   = 4'ha;
	localparam int         RES_W        = 12;
	localparam int         WORD_W       = 16;
	localparam int         FIFO_DEPTH   = 16;
	localparam int         PTR_W        = 4;
	localparam int         CNT_W        = 5;
	localparam int         WAIT_W       = 8;
	localparam int         REPEAT_SHIFT = 2;
	localparam logic [CNT_W-1:0] FIFO_FULL  = 5'h10;
	localparam logic [WAIT_W-1:0] TEMP_HOLD_CYCLES = 8'hbc;
	localparam logic [WAIT_W-1:0] WAKE_CYCLES      = 8'hf4;
	// Kelvin to Celsius in eighths of a degree
	localparam logic [RES_W-1:0]  KELVIN_OFFSET    = 12'h889;
	localparam logic [3:0] SYNC_INIT    = 4'hc;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_WAKE    = 3'b001,
		ST_TEMP_HI = 3'b010,
		ST_TEMP_LO = 3'b011,
		ST_CONV    = 3'b100
	} asc_state_t;

endpackage

// ==== verilog/asc_sync.sv ====
// Two-stage synchroniser for levels entering the reference clock domain
`timescale 1ns/1ps
`default_nettype none
module asc_sync
	import asc_pkg::*;
#(
	parameter int         W    = 4,
	parameter logic [3:0] INIT = SYNC_INIT
) (
	// Clock and reset
	ref_clk,
	rst,
	// Levels
	d,
	q
);
	input  wire logic         ref_clk;
	input  wire logic         rst;
	input  wire logic [W-1:0] d;
	output var  logic [W-1:0] q;

	logic [W-1:0] meta_q;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			meta_q <= INIT[W-1:0];
			q      <= INIT[W-1:0];
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ==== verilog/asc_link.sv ====
// Serial port shifter running on the host's serial clock
`timescale 1ns/1ps
`default_nettype none
module asc_link
	import asc_pkg::*;
(
	// Serial pins
	input  wire logic              sclk,
	input  wire logic              cs_n,
	input  wire logic              din,
	output logic                   dout,
	// Reset from the register side
	input  wire logic              rst,
	// Result word held stable by the register side
	input  wire logic [WORD_W-1:0] rd_word,
	// Received byte with its first flag and toggle, and the word-load toggle
	output logic [7:0]             rx_byte,
	output logic                   rx_first,
	output logic                   rx_tgl,
	output logic                   load_tgl
);
	logic [4:0]        bit_q;
	logic [6:0]        shin_q;
	logic [WORD_W-1:0] shout_q;
	logic              first_q;
	wire               byte_end = (bit_q[2:0] == 3'h7);
	wire               word_ld  = (bit_q[3:0] == 4'h0);

	assign dout = shout_q[WORD_W-1];

	// ------------------------------------------------------------
	// Frame state, cleared whenever the frame ends
	// ------------------------------------------------------------
	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			bit_q   <= 5'h0;
			shin_q  <= 7'h0;
			shout_q <= 16'h0;
			first_q <= 1'h1;
		end else begin
			bit_q   <= 5'(bit_q + 5'h1);
			shin_q  <= {shin_q[5:0], din};
			if (word_ld)
				shout_q <= rd_word;
			else
				shout_q <= {shout_q[WORD_W-2:0], 1'h0};
			if (byte_end)
				first_q <= 1'h0;
		end
	end

	// ------------------------------------------------------------
	// Events toward the register side; toggles survive frame ends
	// ------------------------------------------------------------
	always_ff @(negedge sclk or posedge rst) begin
		if (rst) begin
			rx_byte  <= 8'h0;
			rx_first <= 1'h0;
			rx_tgl   <= 1'h0;
			load_tgl <= 1'h0;
		end else if (!cs_n) begin
			if (byte_end) begin
				rx_byte  <= {shin_q, din};
				rx_first <= first_q;
				rx_tgl   <= ~rx_tgl;
			end
			if (word_ld)
				load_tgl <= ~load_tgl;
		end
	end
endmodule
`default_nettype wire

// ==== verilog/asc_ctrl.sv ====
// Command decode, scan sequencing and result store of the converter
`timescale 1ns/1ps
`default_nettype none
module asc_ctrl
	import asc_pkg::*;
(
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst,
	// Serial port
	input  wire logic             sclk,
	input  wire logic             cs_n,
	input  wire logic             din,
	output logic                  dout,
	// Conversion start pin, active low
	input  wire logic             convert_start_pin_n,
	// Reference hold sources
	input  wire logic             force_bandgap_on,
	input  wire logic             dac_any_up,
	input  wire logic             dac_any_pulled,
	// Channel configuration
	input  wire logic [5:0]       diff_pairs,
	input  wire logic             repeat_count_hi,
	input  wire logic             repeat_count_lo,
	// Converter core
	input  wire logic             adc_done,
	input  wire logic [RES_W-1:0] adc_result,
	output logic                  adc_start,
	output var  asc_adc_req_t     adc_req,
	output logic                  osc_en,
	output logic                  adc_ext_clock,
	// Reference routing, polarity select and scan status
	output logic                  adc_ref_internal,
	output logic                  dac_ref_external,
	output logic                  adc_ref_diff,
	output logic                  sec_ref_is_input,
	output logic                  ref_on,
	output logic [1:0]            polarity_reg_select,
	output logic                  scan_busy
);
	// ------------------------------------------------------------
	// Link and crossing
	// ------------------------------------------------------------
	logic [7:0]        rx_byte;
	logic              rx_first;
	logic              rx_tgl;
	logic              load_tgl;
	logic [3:0]        sync_q;
	logic [2:0]        prev_q;
	logic [WORD_W-1:0] rd_word_q;

	asc_link u_link (
		.sclk     (sclk),
		.cs_n     (cs_n),
		.din      (din),
		.dout     (dout),
		.rst      (rst),
		.rd_word  (rd_word_q),
		.rx_byte  (rx_byte),
		.rx_first (rx_first),
		.rx_tgl   (rx_tgl),
		.load_tgl (load_tgl)
	);

	asc_sync #(.W(4), .INIT(SYNC_INIT)) u_sync (
		.ref_clk (ref_clk),
		.rst     (rst),
		.d       ({cs_n, convert_start_pin_n, rx_tgl, load_tgl}),
		.q       (sync_q)
	);

	// Edge detectors look only at the second stage
	always_ff @(posedge ref_clk) begin
		if (rst)
			prev_q <= SYNC_INIT[2:0];
		else
			prev_q <= sync_q[2:0];
	end

	wire cs_idle    = sync_q[3];
	wire pin_fall   = prev_q[2] & ~sync_q[2];
	wire rx_evt     = prev_q[1] ^ sync_q[1];
	wire load_evt   = prev_q[0] ^ sync_q[0];

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	asc_setup_cmd_t setup_q;
	asc_conv_cmd_t  conv_q;
	asc_state_t     state_q;
	asc_state_t     state_d;

	wire            cmd_evt  = rx_evt & rx_first;
	wire asc_conv_cmd_t conv_in = asc_conv_cmd_t'(rx_byte);
	wire asc_setup_cmd_t setup_in = asc_setup_cmd_t'(rx_byte);
	wire conv_w  = cmd_evt & (conv_in.sel == CONV_SEL);
	wire setup_w = cmd_evt & (setup_in.sel == SETUP_SEL);
	wire wr_start = setup_q.clk_mode[1];
	wire idle     = (state_q == ST_IDLE);
	wire start    = idle & (wr_start ? conv_w : pin_fall);
	wire asc_conv_cmd_t start_cmd = conv_w ? conv_in : conv_q;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			setup_q <= {SETUP_SEL, CLK_MODE_RST, REF_MODE_RST, POL_SEL_RST};
			conv_q  <= '0;
		end else begin
			if (setup_w)
				setup_q <= setup_in;
			if (conv_w)
				conv_q <= conv_in;
		end
	end

	// ------------------------------------------------------------
	// Reference control
	// ------------------------------------------------------------
	wire ref_int   = (setup_q.ref_mode == REF_INT);
	wire ref_hold  = force_bandgap_on |
		(ref_int & (dac_any_up | dac_any_pulled));
	// Temperature always needs the internal reference settled
	wire [WAIT_W-1:0] wait_load = start_cmd.temp ?
		(ref_hold ? TEMP_HOLD_CYCLES : WAKE_CYCLES) :
		((ref_int & ~ref_hold) ? WAKE_CYCLES : '0);

	// ------------------------------------------------------------
	// Channel stepping
	// ------------------------------------------------------------
	logic [3:0]        cur_q;
	logic [3:0]        cur_d;
	logic [CNT_W-1:0]  rep_q;
	logic [CNT_W-1:0]  rep_d;
	logic [WAIT_W-1:0] wait_q;
	logic [WAIT_W-1:0] wait_d;
	logic              inflight_q;

	wire cmd_diff  = diff_pairs[start_cmd.chan[3:1]];
	wire [3:0] n_eff = cmd_diff ? {start_cmd.chan[3:1], 1'h0} :
		start_cmd.chan;
	wire cur_diff  = diff_pairs[cur_q[3:1]];
	wire [3:0] nxt = 4'(cur_q + (cur_diff ? 4'h2 : 4'h1));
	wire [3:0] conv_ch = cur_diff ? {cur_q[3:1], 1'h0} : cur_q;
	wire hit_pin   = (cur_q == START_PIN_CH) |
		(cur_diff & (cur_q[3:1] == START_PIN_CH[3:1]));
	wire hit_sec   = (cur_q == SEC_REF_CH) |
		(cur_diff & (cur_q[3:1] == SEC_REF_CH[3:1]));
	wire skip = (hit_pin & ~setup_q.clk_mode[1]) |
		(hit_sec & setup_q.ref_mode[0]);
	wire [CNT_W-1:0] rep_load = CNT_W'(
		(CNT_W'({repeat_count_hi, repeat_count_lo}) + 5'h1) << REPEAT_SHIFT);
	wire in_conv  = (state_q == ST_CONV);
	wire in_temp  = (state_q == ST_TEMP_HI) | (state_q == ST_TEMP_LO);
	wire issue    = ~inflight_q & (in_temp | (in_conv & ~skip));
	wire conv_end = in_conv & ((~inflight_q & skip) | adc_done);

	logic last;
	always_comb begin
		unique case (conv_q.sweep)
			SW_UP_TO:  last = (nxt > conv_q.chan);
			SW_FROM:   last = (nxt > TOP_CH);
			SW_REPEAT: last = (rep_q == 5'h1);
			SW_ONCE:   last = 1'h1;
		endcase
	end

	// ------------------------------------------------------------
	// Scan sequencer
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		cur_d   = cur_q;
		rep_d   = rep_q;
		wait_d  = wait_q;
		unique case (state_q)
			ST_IDLE: begin
				if (start) begin
					cur_d   = (start_cmd.sweep == SW_UP_TO) ? 4'h0 : n_eff;
					rep_d   = rep_load;
					wait_d  = wait_load;
					if (wait_load != '0)
						state_d = ST_WAKE;
					else
						state_d = start_cmd.temp ? ST_TEMP_HI : ST_CONV;
				end
			end
			ST_WAKE: begin
				if (wait_q == 8'h1)
					state_d = conv_q.temp ? ST_TEMP_HI : ST_CONV;
				else
					wait_d = 8'(wait_q - 8'h1);
			end
			ST_TEMP_HI: begin
				if (adc_done)
					state_d = ST_TEMP_LO;
			end
			ST_TEMP_LO: begin
				if (adc_done)
					state_d = ST_CONV;
			end
			ST_CONV: begin
				if (conv_end) begin
					if (last) begin
						state_d = ST_IDLE;
					end else begin
						rep_d = 5'(rep_q - 5'h1);
						if (conv_q.sweep != SW_REPEAT)
							cur_d = nxt;
					end
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	logic            adc_start_q;
	asc_adc_req_t    adc_req_q;
	logic            osc_en_q;
	logic            ext_clk_q;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_q    <= ST_IDLE;
			cur_q      <= 4'h0;
			rep_q      <= '0;
			wait_q     <= '0;
			inflight_q <= 1'h0;
		end else begin
			state_q    <= state_d;
			cur_q      <= cur_d;
			rep_q      <= rep_d;
			wait_q     <= wait_d;
			inflight_q <= issue | (inflight_q & ~adc_done);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			adc_start_q <= 1'h0;
			adc_req_q   <= '0;
			osc_en_q    <= 1'h0;
			ext_clk_q   <= 1'h0;
		end else begin
			adc_start_q <= issue;
			if (issue)
				adc_req_q <= {conv_ch, cur_diff & ~in_temp, in_temp,
					state_q == ST_TEMP_LO};
			osc_en_q    <= (state_d != ST_IDLE) &
				(setup_q.clk_mode != CLK_EXT);
			ext_clk_q   <= (setup_q.clk_mode == CLK_EXT);
		end
	end

	// ------------------------------------------------------------
	// Temperature slot and result store
	// ------------------------------------------------------------
	logic [RES_W-1:0] temp_hi_q;
	logic [RES_W-1:0] temp_q;
	logic             temp_valid_q;
	logic [RES_W-1:0] mem_q [FIFO_DEPTH];
	logic [PTR_W-1:0] wr_ptr_q;
	logic [PTR_W-1:0] rd_ptr_q;
	logic [CNT_W-1:0] cnt_q;
	logic [1:0]       word_src_q;
	logic             word_upd_q;

	wire temp_store = (state_q == ST_TEMP_LO) & adc_done;
	// Sensor difference minus offset gives eighths of a degree
	wire [RES_W-1:0] temp_calc = temp_hi_q - adc_result - KELVIN_OFFSET;
	wire push     = in_conv & adc_done;
	wire full     = (cnt_q == FIFO_FULL);
	wire pop_temp = load_evt & word_src_q[1];
	wire pop_fifo = load_evt & word_src_q[0] & (cnt_q != '0);
	wire drop     = push & full & ~pop_fifo;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			temp_hi_q    <= '0;
			temp_q       <= '0;
			temp_valid_q <= 1'h0;
		end else begin
			if ((state_q == ST_TEMP_HI) & adc_done)
				temp_hi_q <= adc_result;
			if (temp_store)
				temp_q <= temp_calc;
			temp_valid_q <= temp_store | (temp_valid_q & ~pop_temp);
		end
	end

	for (genvar g = 0; g < FIFO_DEPTH; g++) begin : g_entry
		always_ff @(posedge ref_clk) begin
			if (rst)
				mem_q[g] <= '0;
			else if (push & (wr_ptr_q == PTR_W'(g)))
				mem_q[g] <= adc_result;
		end
	end

	// When full the write lands on the oldest entry and the head moves on
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			cnt_q    <= '0;
		end else begin
			if (push)
				wr_ptr_q <= PTR_W'(wr_ptr_q + 4'h1);
			if (pop_fifo | drop)
				rd_ptr_q <= PTR_W'(rd_ptr_q + 4'h1);
			if ((push & ~full) & ~pop_fifo)
				cnt_q <= CNT_W'(cnt_q + 5'h1);
			else if (pop_fifo & ~push)
				cnt_q <= CNT_W'(cnt_q - 5'h1);
		end
	end

	// The word only changes while the port is idle or just after a load,
	// so the link never samples it mid-change
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rd_word_q  <= '0;
			word_src_q <= 2'h0;
			word_upd_q <= 1'h0;
		end else begin
			word_upd_q <= load_evt;
			if (cs_idle | word_upd_q) begin
				word_src_q <= {temp_valid_q, ~temp_valid_q & (cnt_q != '0)};
				if (temp_valid_q)
					rd_word_q <= {4'h0, temp_q};
				else if (cnt_q != '0)
					rd_word_q <= {4'h0, mem_q[rd_ptr_q]};
				else
					rd_word_q <= '0;
			end
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	logic       ref_int_q;
	logic       dac_ext_q;
	logic       ref_diff_q;
	logic       sec_in_q;
	logic       ref_on_q;
	logic       busy_q;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ref_int_q  <= 1'h1;
			dac_ext_q  <= 1'h1;
			ref_diff_q <= 1'h0;
			sec_in_q   <= 1'h1;
			ref_on_q   <= 1'h0;
			busy_q     <= 1'h0;
		end else begin
			ref_int_q  <= ~setup_q.ref_mode[0];
			dac_ext_q  <= ~ref_int;
			ref_diff_q <= (setup_q.ref_mode == REF_DIFF);
			sec_in_q   <= ~setup_q.ref_mode[0];
			ref_on_q   <= ref_hold | ((state_d != ST_IDLE) &
				(~setup_q.ref_mode[0] | conv_q.temp));
			busy_q     <= (state_d != ST_IDLE);
		end
	end

	assign adc_start           = adc_start_q;
	assign adc_req             = adc_req_q;
	assign osc_en              = osc_en_q;
	assign adc_ext_clock       = ext_clk_q;
	assign adc_ref_internal    = ref_int_q;
	assign dac_ref_external    = dac_ext_q;
	assign adc_ref_diff        = ref_diff_q;
	assign sec_ref_is_input    = sec_in_q;
	assign ref_on              = ref_on_q;
	assign polarity_reg_select = setup_q.pol_sel;
	assign scan_busy           = busy_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence enter_wake_s;
		(idle & start & start_cmd.temp & ref_hold) ##1 (state_q == ST_WAKE);
	endsequence

	write_start_a: assert property (
		(idle & conv_w & wr_start) |=> !idle)
		else $error("conversion write did not start a scan");
	pin_start_a: assert property (
		(idle & pin_fall & !wr_start) |=> !idle)
		else $error("start pin pulse did not start a scan");
	pin_ignored_a: assert property (
		(idle & pin_fall & wr_start & !conv_w) |=> idle)
		else $error("start pin started a scan in write mode");
	setup_decode_a: assert property (
		setup_w |=> (setup_q.ref_mode == $past(rx_byte[3:2])) &&
			(setup_q.clk_mode == $past(rx_byte[5:4])))
		else $error("setup byte fields not taken");
	hold_wait_a: assert property (
		enter_wake_s |->
			##187 (state_q == ST_WAKE) ##1 (state_q != ST_WAKE))
		else $error("temperature wait not 188 cycles");
	temp_first_a: assert property (
		(state_q == ST_TEMP_LO && adc_done) |=>
			temp_valid_q && in_conv && (temp_q == $past(temp_calc)))
		else $error("temperature not stored before channels");
	skip_pin_a: assert property (
		(in_conv && !inflight_q && skip) |=> !adc_start_q)
		else $error("skipped channel was converted");
	diff_pair_a: assert property (
		(issue && in_conv && cur_diff) |=> adc_req_q.diff && !adc_req_q.chan[0])
		else $error("differential pair used odd channel");
	overwrite_a: assert property (
		drop |=> (cnt_q == FIFO_FULL) &&
			(rd_ptr_q == PTR_W'($past(rd_ptr_q) + 4'h1)))
		else $error("full store did not drop oldest");
	empty_zero_a: assert property (
		(cs_idle && !temp_valid_q && cnt_q == '0) |=> rd_word_q == '0)
		else $error("empty store reads nonzero");
endmodule
`default_nettype wire

// ==== testbench/asc_host_model.sv ====
// Host serial master model for the command port
`timescale 1ns/1ps
`default_nettype none
module asc_host_model (
	// Serial pins
	output logic     sclk,
	output logic     cs_n,
	output logic     din,
	input  wire logic dout
);
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		din = 1'b0;
	end
	// ------------------------------------------------------------
	// Frames
	// ------------------------------------------------------------
	// Clock stands high between frames; 64 ns period stays under 25 MHz
	// Frames start only between scans; with clk_mode[1] set a conversion byte starts its scan mid-frame, externally timed ones included
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			din = tx[i];
			#32 sclk = 1'b0;
			#32 sclk = 1'b1;
			rx[i] = dout;
		end
		#32 cs_n = 1'b1;
		// Released line must not keep its last level
		din = ~din;
		#100;
	endtask
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench of the converter command and scan control
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import asc_pkg::*;
	logic             ref_clk, rst, sclk, cs_n, din, dout, pin_n, exp_osc;
	logic             adc_done, adc_start, osc_en, ext_clk, busy;
	logic             ref_int, dac_ext, ref_diff, sec_in, ref_on, fbg, dac_up;
	logic [1:0]       pol, rpt;
	logic [5:0]       pairs;
	logic [15:0]      rd;
	logic [RES_W-1:0] result;
	asc_adc_req_t     req, last_req;
	int               fail_count, total_checks, starts, cnt;
	logic [31:0]      tbl [8] = '{32'h68009804, 32'h6800c204, 32'h6840ac08,
		32'h68c0ac10, 32'h6400c203, 32'h78009e01, 32'h68029e01,
		32'h58009e00};
	logic [5:0]       ref_exp [4] = '{6'h24, 6'h11, 6'h36, 6'h1b};

	asc_host_model u_asc_host_model (.sclk(sclk), .cs_n(cs_n), .din(din),
		.dout(dout));
	asc_ctrl u_asc_ctrl (.ref_clk(ref_clk), .rst(rst), .sclk(sclk),
		.cs_n(cs_n), .din(din), .dout(dout), .convert_start_pin_n(pin_n),
		.force_bandgap_on(fbg), .dac_any_up(dac_up),
		.dac_any_pulled(dac_up), .diff_pairs(pairs),
		.repeat_count_hi(rpt[1]), .repeat_count_lo(rpt[0]),
		.adc_done(adc_done), .adc_result(result), .adc_start(adc_start),
		.adc_req(req), .osc_en(osc_en), .adc_ext_clock(ext_clk),
		.adc_ref_internal(ref_int), .dac_ref_external(dac_ext),
		.adc_ref_diff(ref_diff), .sec_ref_is_input(sec_in), .ref_on(ref_on),
		.polarity_reg_select(pol), .scan_busy(busy));
	wire [5:0]        ref_flags = {ref_int, dac_ext, ref_diff, sec_in, pol};

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// ------------------------------------------------------------
	// Converter core model and tasks
	// ------------------------------------------------------------
	assign result = last_req.temp ? (last_req.bias_low ? 12'h100 : 12'hd00)
		: {8'h50, last_req.chan};
	always @(posedge ref_clk) begin
		adc_done <= 1'b0;
		if (cnt > 0) cnt <= cnt - 1;
		if (cnt == 1) adc_done <= 1'b1;
		if (adc_start === 1'b1) begin
			cnt <= 3;
			starts <= starts + 1;
			last_req <= req;
			chk(16'(osc_en), 16'(exp_osc));
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic setup(input logic [7:0] b);
		u_asc_host_model.xfer({b, 8'h00}, rd);
		cyc(8);
	endtask
	task automatic done_wait(input logic [7:0] n);
		int w;
		w = 0;
		cyc(10);
		while (busy !== 1'b0 && w < 3000) begin
			cyc(1);
			w++;
		end
		cyc(8);
		chk(16'(busy), 16'h0);
		chk(16'(starts), 16'(n));
	endtask
	task automatic pulse(input logic [7:0] n);
		starts = 0;
		pin_n = 1'b0;
		cyc(4);
		pin_n = 1'b1;
		done_wait(n);
	endtask
	task automatic conv(input logic [7:0] cmd, input logic [7:0] n);
		starts = 0;
		u_asc_host_model.xfer({cmd, 8'h00}, rd);
		done_wait(n);
	endtask
	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		rst = 1'b1;
		pin_n = 1'b1;
		pairs = 6'h00;
		adc_done = 1'b0;
		cnt = 0;
		exp_osc = 1'b1;
		fbg = 1'b0;
		dac_up = 1'b0;
		rpt = 2'h0;
		cyc(4);
		rst = 1'b0;
		cyc(4);
		chk({ref_flags, ext_clk, busy}, 8'hd0);
		chk(16'(ref_on), 16'h0);
		for (int r = 0; r < 4; r++) begin
			setup(8'h60 | 8'(r * 5));
			chk(ref_flags, ref_exp[r]);
		end
		dac_up = 1'b1;
		setup(8'h60);
		chk(16'(ref_on), 16'h1);
		dac_up = 1'b0;
		fbg = 1'b1;
		setup(8'h68);
		chk(16'(ref_on), 16'h1);
		conv(8'h9f, 8'h03);
		fbg = 1'b0;
		cyc(2);
		chk(16'(ref_on), 16'h0);
		conv(8'h9f, 8'h03);
		u_asc_host_model.xfer(16'h0000, rd);
		chk(rd, 16'h0377);
		for (int k = 0; k < 3; k++) begin
			u_asc_host_model.xfer(16'h0000, rd);
			chk(rd, (k < 2) ? 16'h0503 : 16'h0000);
		end
		for (int i = 0; i < 8; i++) begin
			pairs = tbl[i][21:16];
			rpt = tbl[i][23:22];
			exp_osc = tbl[i][29:28] != 2'h3;
			setup(tbl[i][31:24]);
			chk(16'(ext_clk), 16'(!exp_osc));
			conv(tbl[i][15:8], tbl[i][7:0]);
		end
		chk({last_req.chan, last_req.diff}, 5'h05);
		setup(8'h48);
		conv(8'h9e, 8'h00);
		pulse(8'h01);
		setup(8'h68);
		pulse(8'h00);
		wrap_up;
	end
	// Frames take about a microsecond each; this allows 300 microseconds in all
	initial begin
		#300000;
		fail_count++;
		wrap_up;
	end
endmodule
`default_nettype wire
